// ==== hdl/drc_consts.svh ====
// Purpose: Offsets, field positions, reset values and counts of the dynamics block
// Assumes: Level and threshold codes share one scale, 0.375 dB a step, FFh = 0 dBFS
// Notes: Definitions only
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH
`define ADDR_CTL 8'h25
`define ADDR_MUG 8'h26
`define ADDR_CTH 8'h27
`define ADDR_CRAT 8'h28
`define ADDR_CATK_LO 8'h29
`define ADDR_CATK_HI 8'h2A
`define REG_RST 8'h00
`define CTL_PEAK 4
`define CTL_WIN 3
`define CTL_EXP_EN 2
`define CTL_LIM_EN 1
`define CTL_COMP_EN 0
`define LEN_LONG 10'h200
`define LEN_SHORT 10'h040
`define SHIFT_LONG 4'h9
`define SHIFT_SHORT 4'h6
`define LOG_OFFSET 10'h071
`define RAT_1P5 5'h01
`define RAT_MAX 5'h14
`define INV_1P5 9'h0AB
`define INV_ONE 9'h100
`define ATT_MAX 11'h3FF
`define COEFF_ONE 44'h1_0000
`define MANT_FRAC 8'h0E
`endif

// ==== hdl/drc_pkg.sv ====
// Purpose: Types shared by the dynamics block
// Assumes: Nothing beyond the constants header
// Notes: Regions double as the last non-linear state
package drc_pkg;
  typedef enum logic [1:0] {REG_LINEAR, REG_COMP, REG_EXP} region_t;
  typedef enum logic [1:0] {ST_COLLECT, ST_MEASURE, ST_DECIDE} blk_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [7:0] exp_th;
    logic [2:0] exp_ratio;
    logic [15:0] comp_release;
    logic [15:0] exp_attack;
    logic [15:0] exp_release;
    logic [7:0] lim_th;
    logic [7:0] lim_target;
  } ext_param_t;
endpackage

// ==== hdl/gain_apply.sv ====
// Purpose: Apply a dB gain to one sample with saturation
// Assumes: net_db in 0.375 dB steps, 16 steps an octave
// Notes: One cycle from in_valid to out_valid
`timescale 1ns/100ps
`include "drc_consts.svh"
module gain_apply
  import drc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic signed [23:0] in_sample,
  input wire logic signed [11:0] net_db,
  output logic out_valid,
  output logic signed [23:0] out_sample
);
  // Fraction of an octave as 2^(f/16), Q14
  function automatic logic [15:0] mant(input logic [3:0] f);
    case (f)
      4'h0: return 16'h4000;
      4'h1: return 16'h42D5;
      4'h2: return 16'h45CB;
      4'h3: return 16'h48E2;
      4'h4: return 16'h4C1C;
      4'h5: return 16'h4F7B;
      4'h6: return 16'h52FF;
      4'h7: return 16'h56AC;
      4'h8: return 16'h5A82;
      4'h9: return 16'h5E84;
      4'hA: return 16'h62B3;
      4'hB: return 16'h6712;
      4'hC: return 16'h6BA2;
      4'hD: return 16'h7066;
      4'hE: return 16'h7560;
      default: return 16'h7A93;
    endcase
  endfunction

  logic signed [7:0] oct;
  logic signed [47:0] prod;
  logic signed [47:0] scaled;
  logic ovf_hi;
  logic ovf_lo;

  assign oct = 8'(net_db >>> 4);
  assign prod = 48'(in_sample) * 48'($signed({1'b0, mant(net_db[3:0])}));
  // Wide product keeps the top octaves of make-up gain exact before clipping
  assign scaled = (oct >= 0) ? ((prod <<< oct) >>> `MANT_FRAC) : (prod >>> 8'(`MANT_FRAC - oct));
  assign ovf_hi = scaled > 48'sh7F_FFFF;
  assign ovf_lo = scaled < -48'sh80_0000;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid <= 1'b0;
      out_sample <= 24'h00_0000;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
        out_sample <= ovf_hi ? 24'h7F_FFFF : ovf_lo ? 24'h80_0000 : scaled[23:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sat_high_a: assert property (in_valid && ovf_hi |=> out_sample == 24'h7F_FFFF)
    else $error("positive overflow not saturated");
  clip_full_a: assert property (in_valid && ovf_lo |=> out_sample == 24'h80_0000)
    else $error("negative overflow not clipped at full scale");
  sat_seen_c: cover property (in_valid && ovf_hi);
endmodule

// ==== hdl/dynamic_range_controller.sv ====
// Purpose: Block level detector, gain calculator and gain smoother for audio
// Assumes: Samples arrive on in_valid at the sample rate, far below core_clk
// Notes: Limiter and expander settings come in on ext_param
`timescale 1ns/100ps
`include "drc_consts.svh"
// How it works
// - Detector measures each sample block, giving peak or average level
// - New target gain computed once per detection block
// - Between expander and compressor thresholds target gain is unity
// - Above compressor threshold attenuation is (1-1/ratio)(level-threshold)
// - Below expander threshold attenuation is (ratio-1)(threshold-level)
// - Compression: falling gain uses compressor attack, rising uses release
// - Expansion: falling gain uses expander attack, rising uses release
// - Linear: return to unity via compressor release or expander attack
// - Applied gain is coeff times last plus one-minus-coeff times target
// - Control bit 4 picks peak (1) or average (0) detection
// - Control bit 3 picks 64 (1) or 512 (0) sample window
// - Control bits 2,1,0 enable expander, limiter, compressor; reset off
// - Make-up gain 0 to 46.5 dB in 1.5 dB steps
// - Threshold code FFh is 0 dB, 0.375 dB less per step
// - Ratio code 01h is 1.5:1, 02h-14h are 2:1-20:1, rest reserved
// - Attack constant is 16 bits over two byte registers, reset zero
// - Output is clipped to never exceed 0 dB full scale
// - Overflowing gain multiply saturates to the largest or most negative representable value
module dynamic_range_controller
  import drc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire ext_param_t ext_param,
  input wire logic in_valid,
  input wire logic signed [23:0] in_sample,
  output logic out_valid,
  output logic signed [23:0] out_sample,
  output logic block_done
);
  // Level in 0.375 dB steps: 16 steps an octave, full scale maps to FFh
  function automatic logic [7:0] level_code(input logic [23:0] m);
    logic [4:0] p;
    logic [23:0] sh;
    logic [9:0] lv;
    p = 5'h00;
    sh = 24'h00_0000;
    lv = 10'h000;
    for (int i = 0; i < 24; i++)
      if (m[i])
        p = 5'(i);
    sh = m << (5'h17 - p);
    lv = {1'b0, p, sh[22:19]};
    if (m == 24'h00_0000 || lv < `LOG_OFFSET)
      return 8'h00;
    return 8'(lv - `LOG_OFFSET);
  endfunction

  // Returns 1/ratio in Q8; reserved codes act as 1:1
  function automatic logic [8:0] comp_inv(input logic [4:0] r);
    if (r == `RAT_1P5)
      return `INV_1P5;
    if (r >= 5'h02 && r <= `RAT_MAX)
      return 9'(16'h0100 / {11'h000, r});
    return `INV_ONE;
  endfunction

  logic [4:0] ctl_q;
  logic [4:0] mug_q;
  logic [7:0] cth_q;
  logic [4:0] crat_q;
  logic [15:0] catk_q;
  logic [9:0] cnt_q;
  logic [32:0] sum_q;
  logic [23:0] peak_q;
  logic [23:0] snap_avg_q;
  logic [23:0] snap_peak_q;
  logic [7:0] level_q;
  logic [9:0] target_q;
  logic [15:0] coeff_q;
  logic [25:0] g_q;
  blk_state_t st_q;
  region_t last_nl_q;
  region_t region_d;
  logic [23:0] mag;
  logic [23:0] peak_d;
  logic [32:0] sum_d;
  logic [9:0] blk_len;
  logic [3:0] blk_shift;
  logic last;
  logic any_en;
  logic [8:0] over;
  logic [8:0] under;
  logic [16:0] cprod;
  logic [10:0] eprod;
  logic [2:0] exp_fac;
  logic [10:0] lim_att;
  logic [10:0] att_raw;
  logic [9:0] att_new;
  logic [15:0] coeff_d;
  logic [43:0] acc;
  logic [10:0] att_round;
  logic [9:0] att_int;
  logic signed [11:0] net_db;

  assign any_en = ctl_q[`CTL_EXP_EN] | ctl_q[`CTL_LIM_EN] | ctl_q[`CTL_COMP_EN];

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctl_q <= 5'h00;
      mug_q <= 5'h00;
      cth_q <= `REG_RST;
      crat_q <= 5'h00;
      catk_q <= 16'h0000;
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        `ADDR_CTL: ctl_q <= reg_req.wdata[4:0];
        `ADDR_MUG: mug_q <= reg_req.wdata[4:0];
        `ADDR_CTH: cth_q <= reg_req.wdata;
        `ADDR_CRAT: crat_q <= reg_req.wdata[4:0];
        `ADDR_CATK_LO: catk_q[7:0] <= reg_req.wdata;
        `ADDR_CATK_HI: catk_q[15:8] <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        `ADDR_CTL: reg_rdata <= {3'h0, ctl_q};
        `ADDR_MUG: reg_rdata <= {3'h0, mug_q};
        `ADDR_CTH: reg_rdata <= cth_q;
        `ADDR_CRAT: reg_rdata <= {3'h0, crat_q};
        `ADDR_CATK_LO: reg_rdata <= catk_q[7:0];
        `ADDR_CATK_HI: reg_rdata <= catk_q[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign blk_len = ctl_q[`CTL_WIN] ? `LEN_SHORT : `LEN_LONG;
  assign blk_shift = ctl_q[`CTL_WIN] ? `SHIFT_SHORT : `SHIFT_LONG;
  assign mag = in_sample[23] ? 24'(-in_sample) : 24'(in_sample);
  assign peak_d = (mag > peak_q) ? mag : peak_q;
  assign sum_d = sum_q + 33'(mag);
  // Compare with >= so a window shortened mid-block still closes
  assign last = in_valid && (cnt_q >= blk_len - 10'h001);

  // block accumulation, restarts without losing a sample
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= 10'h000;
      sum_q <= 33'h0_0000_0000;
      peak_q <= 24'h00_0000;
      snap_avg_q <= 24'h00_0000;
      snap_peak_q <= 24'h00_0000;
    end
    else if (last)
    begin
      cnt_q <= 10'h000;
      sum_q <= 33'h0_0000_0000;
      peak_q <= 24'h00_0000;
      snap_avg_q <= 24'(sum_d >> blk_shift);
      snap_peak_q <= peak_d;
    end
    else if (in_valid)
    begin
      cnt_q <= cnt_q + 10'h001;
      sum_q <= sum_d;
      peak_q <= peak_d;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= ST_COLLECT;
    else
    begin
      case (st_q)
        ST_COLLECT: st_q <= last ? ST_MEASURE : ST_COLLECT;
        ST_MEASURE: st_q <= ST_DECIDE;
        ST_DECIDE: st_q <= ST_COLLECT;
        default: st_q <= ST_COLLECT;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      level_q <= 8'h00;
    else if (st_q == ST_MEASURE)
      level_q <= level_code(ctl_q[`CTL_PEAK] ? snap_peak_q : snap_avg_q);
  end

  always_comb
  begin
    over = {1'b0, level_q} - {1'b0, cth_q};
    under = {1'b0, ext_param.exp_th} - {1'b0, level_q};
    cprod = {9'h000, over[7:0]} * {8'h00, 9'h100 - comp_inv(crat_q)};
    // expander ratio 2..7, lower codes reserved
    exp_fac = (ext_param.exp_ratio >= 3'h2) ? ext_param.exp_ratio - 3'h1 : 3'h0;
    eprod = {3'h0, under[7:0]} * {8'h00, exp_fac};
    lim_att = 11'h000;
    if (ctl_q[`CTL_LIM_EN] && level_q > ext_param.lim_th && level_q > ext_param.lim_target)
      lim_att = {3'h0, level_q - ext_param.lim_target};
    if (ctl_q[`CTL_COMP_EN] && level_q > cth_q)
      region_d = REG_COMP;
    else if (ctl_q[`CTL_EXP_EN] && level_q < ext_param.exp_th)
      region_d = REG_EXP;
    else
      region_d = REG_LINEAR;
    case (region_d)
      REG_COMP: att_raw = {2'h0, cprod[16:8]};
      REG_EXP: att_raw = eprod;
      default: att_raw = 11'h000;
    endcase
    if (lim_att > att_raw)
      att_raw = lim_att;
    att_new = (att_raw > `ATT_MAX) ? 10'(`ATT_MAX) : att_raw[9:0];
    // coefficient choice, more attenuation means lower gain
    case (region_d)
      REG_COMP: coeff_d = (att_new > target_q) ? catk_q : ext_param.comp_release;
      REG_EXP: coeff_d = (att_new > target_q) ? ext_param.exp_attack : ext_param.exp_release;
      default: coeff_d = (last_nl_q == REG_EXP) ? ext_param.exp_attack : ext_param.comp_release;
    endcase
    if (!any_en)
      coeff_d = 16'h0000;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      target_q <= 10'h000;
      coeff_q <= 16'h0000;
      last_nl_q <= REG_LINEAR;
    end
    else if (st_q == ST_DECIDE || !any_en)
    begin
      target_q <= att_new;
      coeff_q <= coeff_d;
      if (region_d != REG_LINEAR)
        last_nl_q <= region_d;
    end
  end

  // tracking filter on attenuation, one step per sample
  assign acc = 44'(coeff_q) * 44'(g_q) + (`COEFF_ONE - 44'(coeff_q)) * 44'({target_q, 16'h0000});

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      g_q <= 26'h000_0000;
    else if (!any_en)
      g_q <= 26'h000_0000;
    else if (in_valid)
      g_q <= acc[41:16];
  end

  assign att_round = {1'b0, g_q[25:16]} + {10'h000, g_q[15]};
  assign att_int = (att_round > `ATT_MAX) ? 10'(`ATT_MAX) : att_round[9:0];
  // make-up is four 0.375 dB steps per code
  assign net_db = $signed({5'h00, mug_q, 2'h0}) - $signed({2'h0, att_int});

  gain_apply u_gain (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(in_valid),
    .in_sample(in_sample),
    .net_db(net_db),
    .out_valid(out_valid),
    .out_sample(out_sample)
  );

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      block_done <= 1'b0;
    else
      block_done <= (st_q == ST_DECIDE);
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  block_seq_a: assert property (last |=> st_q == ST_MEASURE ##1 st_q == ST_DECIDE ##1 block_done)
    else $error("block decision sequence broken");
  unity_lin_a: assert property (st_q == ST_DECIDE && region_d == REG_LINEAR && lim_att == 11'h000
    |=> target_q == 10'h000)
    else $error("linear region target not unity");
  comp_half_a: assert property (st_q == ST_DECIDE && region_d == REG_COMP && crat_q == 5'h02
    && lim_att == 11'h000 |=> target_q == 10'($past(over[7:1])))
    else $error("2:1 compression attenuation wrong");
  exp_unit_a: assert property (st_q == ST_DECIDE && region_d == REG_EXP && ext_param.exp_ratio == 3'h2
    && lim_att == 11'h000 |=> target_q == 10'($past(under[7:0])))
    else $error("1:2 expansion attenuation wrong");
  comp_attack_a: assert property (st_q == ST_DECIDE && region_d == REG_COMP && att_new > target_q
    |=> coeff_q == $past(catk_q))
    else $error("compressor attack not chosen");
  exp_release_a: assert property (st_q == ST_DECIDE && region_d == REG_EXP && att_new <= target_q
    |=> coeff_q == $past(ext_param.exp_release))
    else $error("expander release not chosen");
  lin_return_a: assert property (st_q == ST_DECIDE && region_d == REG_LINEAR && any_en
    && last_nl_q == REG_EXP |=> coeff_q == $past(ext_param.exp_attack))
    else $error("linear return after expansion not expander attack");
  smooth_step_a: assert property (in_valid && any_en && coeff_q == 16'h0000 && st_q != ST_DECIDE
    |=> g_q == {$past(target_q), 16'h0000})
    else $error("zero coefficient did not jump to target");
  avg_level_a: assert property (st_q == ST_MEASURE && !ctl_q[`CTL_PEAK]
    |=> level_q == level_code($past(snap_avg_q)))
    else $error("average level not used");
  bypass_a: assert property (!any_en |=> g_q == 26'h000_0000 && target_q == 10'h000)
    else $error("disabled dynamics still alter gain");
  comp_seen_c: cover property (st_q == ST_DECIDE && region_d == REG_COMP);
  exp_seen_c: cover property (st_q == ST_DECIDE && region_d == REG_EXP);
  short_win_c: cover property (last && ctl_q[`CTL_WIN]);
endmodule

// ==== sim/drc_stream_partner.sv ====
// Purpose: Upstream sample source and downstream sink for the dynamics block
// Assumes: Samples five core_clk cycles apart, above the minimum spacing of four
// Notes: Data line shows the inverse of the last sample between strobes
`timescale 1ns/100ps
module drc_stream_partner
(
  input wire logic core_clk,
  output logic in_valid,
  output logic signed [23:0] in_sample,
  input wire logic out_valid,
  input wire logic signed [23:0] out_sample,
  input wire logic block_done,
  output logic signed [23:0] last_out,
  output int blocks
);
  initial
  begin
    in_valid = 1'b0;
    in_sample = 24'h00_0000;
    last_out = 24'h00_0000;
    blocks = 0;
  end

  always @(posedge core_clk)
  begin
    if (out_valid)
      last_out <= out_sample;
    if (block_done)
      blocks <= blocks + 1;
  end

  task automatic send(input logic signed [23:0] x);
    @(posedge core_clk);
    #1;
    in_valid = 1'b1;
    in_sample = x;
    @(posedge core_clk);
    #1;
    in_valid = 1'b0;
    // Drive the inverse of the sample, so no stale data
    in_sample = ~x;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
endmodule

// ==== sim/tb_dynamic_range_controller.sv ====
// Purpose: Self-checking bench for the dynamics block
// Assumes: Level code 16 steps an octave, FFh at full scale
// Notes: Gain checks read the last output of the block after the one measured
`timescale 1ns/100ps
`include "drc_consts.svh"
module tb_dynamic_range_controller
  import drc_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t rq = '0;
  ext_param_t ep;
  logic [7:0] reg_rdata;
  logic in_valid;
  logic signed [23:0] in_sample;
  logic out_valid;
  logic signed [23:0] out_sample;
  logic block_done;
  logic signed [23:0] last_out;
  int blocks;
  int bad_count = 0;
  int comparisons = 0;
  int b0;
  logic [7:0] d;
  logic [7:0] rb [6] = '{8'h1F, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF};

  always #12.5 core_clk = ~core_clk;

  dynamic_range_controller dut (.core_clk(core_clk), .reset_n(reset_n), .reg_req(rq), .reg_rdata(reg_rdata),
    .ext_param(ep), .in_valid(in_valid), .in_sample(in_sample), .out_valid(out_valid),
    .out_sample(out_sample), .block_done(block_done));
  drc_stream_partner src (.core_clk(core_clk), .in_valid(in_valid), .in_sample(in_sample),
    .out_valid(out_valid), .out_sample(out_sample), .block_done(block_done), .last_out(last_out),
    .blocks(blocks));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    rq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    #1;
    rq = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #1;
    rq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    #1;
    rq = '0;
    v = reg_rdata;
  endtask

  // Half pattern zeroes even samples, so the last sample still carries amplitude
  task automatic blk(input logic signed [23:0] a, input bit half, input int n);
    for (int k = 0; k < n; k++)
      src.send((half && k[0] == 1'b0) ? 24'sh00_0000 : a);
  endtask

  task automatic blk2(input logic signed [23:0] a, input bit half);
    blk(a, half, 64);
    blk(a, half, 64);
  endtask

  // Gain window in percent, wide enough for the design's rounding
  function automatic logic [23:0] in_rng(input logic signed [23:0] o, input logic signed [23:0] a,
    input int lo, input int hi);
    return 24'((100 * longint'(o) > lo * longint'(a)) && (100 * longint'(o) < hi * longint'(a)));
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end

  initial
  begin
    // Thresholds and ratios kept in the advised ranges
    ep = '{exp_th: 8'h7F, exp_ratio: 3'h2, comp_release: 16'h0000, exp_attack: 16'h0000,
      exp_release: 16'h0000, lim_th: 8'hE7, lim_target: 8'hDF};
    repeat (8) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    for (int a = 8'h24; a < 8'h2C; a++)
    begin
      rd(a[7:0], d);
      chk(24'(d), 24'h00_0000);
    end
    for (int i = 0; i < 6; i++)
    begin
      wr(8'h25 + i[7:0], 8'hFF);
      rd(8'h25 + i[7:0], d);
      chk(24'(d), 24'(rb[i]));
    end
    wr(8'h2B, 8'hFF);
    rd(8'h2B, d);
    chk(24'(d), 24'h00_0000);
    wr(`ADDR_CATK_LO, 8'h00);
    wr(`ADDR_CATK_HI, 8'h00);
    wr(`ADDR_MUG, 8'h00);
    $display("registers done");
    wr(`ADDR_CTL, 8'h01);
    wr(`ADDR_CTH, 8'hFF);
    wr(`ADDR_CRAT, 8'h04);
    b0 = blocks;
    blk(24'sh00_1000, 1'b0, 511);
    chk(24'(blocks - b0), 24'h00_0000);
    blk(24'sh00_1000, 1'b0, 1);
    chk(24'(blocks - b0), 24'h00_0001);
    wr(`ADDR_CTL, 8'h09);
    blk(24'sh00_1000, 1'b0, 64);
    chk(24'(blocks - b0), 24'h00_0002);
    $display("window done");
    wr(`ADDR_CTL, 8'h08);
    blk(24'sh12_3456, 1'b0, 64);
    chk(last_out, 24'h12_3456);
    blk(-24'sh12_3456, 1'b0, 64);
    chk(last_out, 24'hED_CBAA);
    wr(`ADDR_MUG, 8'h04);
    blk(24'sh12_3456, 1'b0, 64);
    chk(last_out, 24'h24_68AC);
    wr(`ADDR_MUG, 8'h1F);
    blk(24'sh60_0000, 1'b0, 64);
    chk(last_out, 24'h7F_FFFF);
    blk(-24'sh60_0000, 1'b0, 64);
    chk(last_out, 24'h80_0000);
    wr(`ADDR_MUG, 8'h00);
    $display("bypass and make-up done");
    // Slow release, instant attack: a wrong pick shows as a jump
    ep.comp_release = 16'hFF00;
    wr(`ADDR_CTH, 8'hBF);
    wr(`ADDR_CTL, 8'h19);
    blk2(24'sh40_0000, 1'b0);
    chk(in_rng(last_out, 24'sh40_0000, 19, 24), 24'h00_0001);
    blk2(24'sh20_0000, 1'b0);
    chk(in_rng(last_out, 24'sh20_0000, 20, 31), 24'h00_0001);
    ep.comp_release = 16'h0000;
    blk2(24'sh04_0000, 1'b0);
    chk(last_out, 24'h04_0000);
    $display("compressor done");
    wr(`ADDR_CTH, 8'hE7);
    wr(`ADDR_CTL, 8'h09);
    blk2(24'sh40_0000, 1'b1);
    chk(last_out, 24'h40_0000);
    wr(`ADDR_CTL, 8'h19);
    blk2(24'sh40_0000, 1'b1);
    chk(in_rng(last_out, 24'sh40_0000, 70, 85), 24'h00_0001);
    $display("detector done");
    wr(`ADDR_CTL, 8'h1A);
    blk2(24'sh40_0000, 1'b0);
    chk(in_rng(last_out, 24'sh40_0000, 45, 55), 24'h00_0001);
    wr(`ADDR_CTL, 8'h1C);
    blk2(24'sh00_4000, 1'b0);
    chk(in_rng(last_out, 24'sh00_4000, 45, 55), 24'h00_0001);
    $display("limiter and expander done");
    // Slow compressor release would show as a residual ramp
    ep.comp_release = 16'hFF00;
    blk2(24'sh04_0000, 1'b0);
    chk(last_out, 24'h04_0000);
    ep.comp_release = 16'h0000;
    wr(`ADDR_CRAT, 8'h02);
    wr(`ADDR_CTH, 8'hBF);
    wr(`ADDR_CTL, 8'h19);
    blk2(24'sh40_0000, 1'b0);
    chk(in_rng(last_out, 24'sh40_0000, 33, 38), 24'h00_0001);
    wr(`ADDR_CRAT, 8'h01);
    blk2(24'sh40_0000, 1'b0);
    chk(in_rng(last_out, 24'sh40_0000, 48, 55), 24'h00_0001);
    wr(`ADDR_CRAT, 8'h15);
    blk2(24'sh40_0000, 1'b0);
    chk(last_out, 24'h40_0000);
    $display("ratio codes done");
    wrap_up();
  end
endmodule
